// ---- rtl/fsod_pkg.sv ----
// Package with register map, field layout and types for the security decode.
package fsod_pkg;

	localparam logic [31:0] FSOD_ADDR_SECBYTE  = 32'h0000_0000;
	localparam logic [31:0] FSOD_ADDR_STATUS   = 32'h0000_0004;
	localparam logic [31:0] FSOD_ADDR_CONTROL  = 32'h0000_0008;
	localparam logic [31:0] FSOD_ADDR_PROTECT  = 32'h0000_000C;

	localparam int FSOD_KEY_POS   = 6;
	localparam int FSOD_MASS_POS  = 4;
	localparam int FSOD_FACT_POS  = 2;
	localparam int FSOD_STATE_POS = 0;

	localparam logic [1:0] FSOD_KEY_ENABLED   = 2'h2;
	localparam logic [1:0] FSOD_MASS_DISABLED = 2'h2;
	localparam logic [1:0] FSOD_UNSECURE      = 2'h2;
	localparam logic [1:0] FSOD_FACT_GRANT_A  = 2'h0;
	localparam logic [1:0] FSOD_FACT_GRANT_B  = 2'h3;

	localparam logic [7:0]  FSOD_SECBYTE_RESET = 8'h00;
	localparam logic [31:0] FSOD_PROTECT_RESET = 32'h0000_0000;
	localparam logic [1:0]  FSOD_RESP_OKAY     = 2'h0;
	localparam logic [1:0]  FSOD_RESP_SLVERR   = 2'h2;
	localparam int          FSOD_REGIONS       = 32;

	typedef struct packed {
		logic       secure;
		logic       backdoor_key_allow;
		logic       mass_erase_allow;
		logic       factory_analysis_access;
		logic       unlocked;
		logic       loaded;
	} fsod_status_t;

	typedef struct packed {
		logic       is_erase_or_prog;
		logic [4:0] region;
	} fsod_op_t;

endpackage : fsod_pkg

// ---- rtl/fsod_top.sv ----
// Security configuration byte decode with an AXI4-Lite register slave.
// Operation
// (RULE1) At each reset the settings are reloaded from the byte supplied by the stored image.
// (RULE2) The decoded settings are handed out as status outputs for the chip system logic.
// (RULE3) Firmware reads, erases and programs pass unchanged while secure, mass erase aside.
// (RULE4) Region protection blocks only erase and program aimed at protected regions.
// (RULE5) The byte is eight bits: key enable 7-6, mass erase 5-4, factory 3-2, state 1-0.
// (RULE6) Backdoor key unlock is allowed only when its field holds 10.
// (RULE7) The mass erase field decides debug-port and serial-port mass erase.
// (RULE8) The mass erase field applies only while secure; unsecure always allows it.
// (RULE9) The mass erase field disables mass erase only for 10.
// (RULE10) The state field decodes unsecure only for 10, all else is secure.
// (RULE11) A successful backdoor unlock forces the effective state field to 10.
// (RULE12) Factory access is granted for 00 and 11, and matters only while secure.
//
// Local design decisions: the placing of the registers and the AXI4-Lite register port.
module fsod_top (
	input  wire logic                 clk_i,
	input  wire logic                 arst_n_i,
	input  wire logic [7:0]           nvm_byte_i,
	input  wire logic                 nvm_valid_i,
	input  wire logic                 key_match_i,
	input  wire fsod_pkg::fsod_op_t   fw_op_i,
	output logic                      fw_op_allow_o,
	output fsod_pkg::fsod_status_t    status_o,
	input  wire logic [31:0]          s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [31:0]          s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready
);
	import fsod_pkg::*;

	logic [7:0]  sec_byte_reg;
	logic        loaded_reg;
	logic        unlock_reg;
	logic        unlock_req_reg;
	logic [31:0] protect_reg;
	logic [1:0]  eff_state;
	logic        secure;
	logic        key_allow;
	logic        mass_allow;
	logic        fact_allow;
	logic        region_prot;
	logic        aw_held_reg;
	logic        w_held_reg;
	logic [31:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0]  wstrb_reg;
	logic        do_write;
	logic        wr_ok;
	logic [1:0]  bresp_reg;
	logic        bvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0]  rresp_reg;
	logic        rvalid_reg;

	// The byte is captured by a clock edge after release, never at reset itself.
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sec_byte_reg <= FSOD_SECBYTE_RESET; // RULE1
			loaded_reg   <= 1'b0;
		end else if (nvm_valid_i && !loaded_reg) begin
			sec_byte_reg <= nvm_byte_i; // RULE1
			loaded_reg   <= 1'b1;
		end
	end

	// Unlock lasts until the next reset, which reloads the stored byte.
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			unlock_reg <= 1'b0;
		end else if (unlock_req_reg && key_match_i && key_allow && loaded_reg) begin
			unlock_reg <= 1'b1; // RULE11
		end
	end

	// Key decode waits for the loaded byte, mass and factory decode the reset byte; until loading the part is secure.
	always_comb begin
		eff_state  = unlock_reg ? FSOD_UNSECURE
			: sec_byte_reg[FSOD_STATE_POS +: 2]; // RULE11
		secure     = !loaded_reg || (eff_state != FSOD_UNSECURE); // RULE10
		key_allow  = loaded_reg
			&& (sec_byte_reg[FSOD_KEY_POS +: 2] == FSOD_KEY_ENABLED); // RULE6
		mass_allow = !secure
			|| (sec_byte_reg[FSOD_MASS_POS +: 2] != FSOD_MASS_DISABLED); // RULE7 RULE8 RULE9
		fact_allow = !secure
			|| (sec_byte_reg[FSOD_FACT_POS +: 2] == FSOD_FACT_GRANT_A)
			|| (sec_byte_reg[FSOD_FACT_POS +: 2] == FSOD_FACT_GRANT_B); // RULE12
	end

	always_comb begin
		status_o.secure                  = secure; // RULE2
		status_o.backdoor_key_allow      = key_allow; // RULE2
		status_o.mass_erase_allow        = mass_allow; // RULE2
		status_o.factory_analysis_access = fact_allow; // RULE2
		status_o.unlocked                = unlock_reg;
		status_o.loaded                  = loaded_reg;
	end

	// Security state is deliberately not an input here: firmware is gated only by region protection.
	always_comb begin
		region_prot   = protect_reg[fw_op_i.region];
		fw_op_allow_o = !(fw_op_i.is_erase_or_prog && region_prot); // RULE3 RULE4
	end

	// AXI4-Lite write channels are held independently, so either may come first.
	assign s_axi_awready = !aw_held_reg && !bvalid_reg;
	assign s_axi_wready  = !w_held_reg && !bvalid_reg;
	assign do_write      = aw_held_reg && w_held_reg && !bvalid_reg;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			aw_held_reg <= 1'b0;
			awaddr_reg  <= 32'h0000_0000;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held_reg <= 1'b1;
			awaddr_reg  <= s_axi_awaddr;
		end else if (do_write) begin
			aw_held_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			w_held_reg <= 1'b0;
			wdata_reg  <= 32'h0000_0000;
			wstrb_reg  <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held_reg <= 1'b1;
			wdata_reg  <= s_axi_wdata;
			wstrb_reg  <= s_axi_wstrb;
		end else if (do_write) begin
			w_held_reg <= 1'b0;
		end
	end

	always_comb begin
		wr_ok = (awaddr_reg[31:2] == FSOD_ADDR_CONTROL[31:2])
			|| (awaddr_reg[31:2] == FSOD_ADDR_PROTECT[31:2]);
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			protect_reg <= FSOD_PROTECT_RESET;
		end else if (do_write
			&& awaddr_reg[31:2] == FSOD_ADDR_PROTECT[31:2]) begin
			for (int i = 0; i < 4; i++) begin
				if (wstrb_reg[i]) begin
					protect_reg[8*i +: 8] <= wdata_reg[8*i +: 8]; // RULE4
				end
			end
		end
	end

	// Writing one to bit 0 of the control word arms one unlock attempt.
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			unlock_req_reg <= 1'b0;
		end else if (do_write && wstrb_reg[0]
			&& awaddr_reg[31:2] == FSOD_ADDR_CONTROL[31:2]) begin
			unlock_req_reg <= wdata_reg[0];
		end else begin
			unlock_req_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			bvalid_reg <= 1'b0;
			bresp_reg  <= FSOD_RESP_OKAY;
		end else if (do_write) begin
			bvalid_reg <= 1'b1;
			bresp_reg  <= wr_ok ? FSOD_RESP_OKAY : FSOD_RESP_SLVERR;
		end else if (bvalid_reg && s_axi_bready) begin
			bvalid_reg <= 1'b0;
		end
	end

	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_arready = !rvalid_reg;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= 32'h0000_0000;
			rresp_reg  <= FSOD_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_reg <= 1'b1;
			rresp_reg  <= FSOD_RESP_OKAY;
			unique case (s_axi_araddr[31:2])
				FSOD_ADDR_SECBYTE[31:2]: rdata_reg <= {24'h000000, sec_byte_reg}; // RULE5
				FSOD_ADDR_STATUS[31:2]:  rdata_reg <= {26'h0000000, status_o};
				FSOD_ADDR_CONTROL[31:2]: rdata_reg <= 32'h0000_0000;
				FSOD_ADDR_PROTECT[31:2]: rdata_reg <= protect_reg;
				default: begin
					rdata_reg <= 32'h0000_0000;
					rresp_reg <= FSOD_RESP_SLVERR;
				end
			endcase
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata  = rdata_reg;
	assign s_axi_rresp  = rresp_reg;

endmodule // fsod_top

// ---- dv/fsod_top_properties.sv ----
// Checker that ties the decode outputs to the byte taken at load.
module fsod_top_properties (
	input  wire logic                  clk_i,
	input  wire logic                  arst_n_i,
	input  wire logic [7:0]            nvm_byte_i,
	input  wire logic                  nvm_valid_i,
	input  wire fsod_pkg::fsod_op_t    fw_op_i,
	input  wire logic                  fw_op_allow_o,
	input  wire fsod_pkg::fsod_status_t status_o,
	input  wire logic                  s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic                  s_axi_rvalid,
	input  wire logic                  s_axi_rready
);
	import fsod_pkg::*;
	logic [7:0] cap_reg;
	logic       dec_ok;
	logic       sec_exp;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	// The byte input may move after load, so the checker keeps its own copy.
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			cap_reg <= 8'h00;
		else if (nvm_valid_i && !status_o.loaded)
			cap_reg <= nvm_byte_i;
	end
	assign dec_ok = status_o.loaded && !status_o.unlocked;
	assign sec_exp = cap_reg[1:0] != FSOD_UNSECURE;
	sequence load_s;
		nvm_valid_i && !status_o.loaded;
	endsequence
	load_take_a: assert property (load_s |=> status_o.loaded &&
		status_o.secure == ($past(nvm_byte_i[1:0]) != FSOD_UNSECURE))
		else $error("load did not decode the byte");
	load_stays_a: assert property (status_o.loaded |=> status_o.loaded[*3])
		else $error("loaded flag dropped");
	state_dec_a: assert property (dec_ok |-> status_o.secure == sec_exp)
		else $error("state decode wrong");
	key_dec_a: assert property (dec_ok |-> status_o.backdoor_key_allow ==
		(cap_reg[7:6] == FSOD_KEY_ENABLED)) else $error("key decode wrong");
	mass_dec_a: assert property (dec_ok |-> status_o.mass_erase_allow ==
		(!sec_exp || cap_reg[5:4] != FSOD_MASS_DISABLED))
		else $error("mass erase decode wrong");
	factory_dec_a: assert property (dec_ok |-> status_o.factory_analysis_access ==
		(!sec_exp || cap_reg[3:2] == FSOD_FACT_GRANT_A ||
		cap_reg[3:2] == FSOD_FACT_GRANT_B)) else $error("factory decode wrong");
	unlock_force_a: assert property (status_o.unlocked |-> !status_o.secure &&
		status_o.mass_erase_allow) else $error("unlock did not unsecure");
	op_pass_a: assert property (!fw_op_i.is_erase_or_prog |-> fw_op_allow_o)
		else $error("read blocked");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
	rresp_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
		else $error("read response dropped");
endmodule // fsod_top_properties

bind fsod_top fsod_top_properties u_chk (.clk_i, .arst_n_i, .nvm_byte_i,
	.nvm_valid_i, .fw_op_i, .fw_op_allow_o, .status_o, .s_axi_bvalid,
	.s_axi_bready, .s_axi_rvalid, .s_axi_rready);

// ---- dv/fsod_top_tb.sv ----
// Self-checking bench for the security decode and its register slave.
module fsod_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import fsod_pkg::*;
	logic         clk_i, arst_n_i, nvm_valid_i, key_match_i, fw_op_allow_o;
	logic         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic         s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic         s_axi_rvalid, s_axi_rready;
	logic [1:0]   s_axi_bresp, s_axi_rresp, rsp;
	logic [3:0]   s_axi_wstrb;
	logic [7:0]   nvm_byte_i;
	logic [31:0]  s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, q;
	fsod_op_t     fw_op_i;
	fsod_status_t status_o;
	int           fail_count, checks, cyc;

	fsod_top uut (.clk_i, .arst_n_i, .nvm_byte_i, .nvm_valid_i, .key_match_i,
		.fw_op_i, .fw_op_allow_o, .status_o, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	task close_out;
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	always @(posedge clk_i) begin
		cyc++;
		if (cyc > 20000) begin
			fail_count++;
			close_out;
		end
	end

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %0t saw %h expected %h", $time, seen, exp);
		end
	endtask

	function automatic logic [5:0] dec(input logic [7:0] b);
		logic s;
		s = b[1:0] != 2'h2;
		return {s, b[7:6] == 2'h2, !s || b[5:4] != 2'h2,
			!s || b[3:2] == 2'h0 || b[3:2] == 2'h3, 2'b01};
	endfunction

	// Each channel is released at the edge after it was seen taken.
	task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
		logic ah, wh, rh, dn;
		dn = 1'b0;
		@(posedge clk_i);
		if (w) begin
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= 1'b1;
		end else begin
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			s_axi_rready <= 1'b1;
		end
		while (!dn) begin
			@(negedge clk_i);
			ah = s_axi_awvalid && s_axi_awready;
			wh = s_axi_wvalid && s_axi_wready;
			rh = s_axi_arvalid && s_axi_arready;
			dn = w ? s_axi_bvalid : s_axi_rvalid;
			rsp = w ? s_axi_bresp : s_axi_rresp;
			q = s_axi_rdata;
			@(posedge clk_i);
			if (ah) s_axi_awvalid <= 1'b0;
			if (wh) s_axi_wvalid <= 1'b0;
			if (rh) s_axi_arvalid <= 1'b0;
			if (dn) s_axi_bready <= 1'b0;
			if (dn) s_axi_rready <= 1'b0;
		end
	endtask

	task ld(input logic [7:0] b);
		arst_n_i <= 1'b0;
		nvm_valid_i <= 1'b0;
		repeat (5) @(posedge clk_i);
		arst_n_i <= 1'b1;
		nvm_byte_i <= b;
		nvm_valid_i <= 1'b1;
		@(posedge clk_i) nvm_byte_i <= ~b;
		@(negedge clk_i) chk(status_o, dec(b));
		@(negedge clk_i) chk(status_o, dec(b));
		@(posedge clk_i) nvm_valid_i <= 1'b0;
	endtask

	task op(input logic [5:0] o, input logic e);
		@(posedge clk_i) fw_op_i <= o;
		@(negedge clk_i) chk(fw_op_allow_o, e);
	endtask

	task unl(input logic [7:0] b, input logic m, input logic [3:0] e);
		ld(b);
		key_match_i <= m;
		xfer(1'b1, FSOD_ADDR_CONTROL, 32'h0000_0001);
		chk(rsp, FSOD_RESP_OKAY);
		@(negedge clk_i);
		chk({status_o.unlocked, status_o.secure, status_o.mass_erase_allow,
			status_o.factory_analysis_access}, e);
	endtask

	initial begin
		{arst_n_i, nvm_valid_i, key_match_i, s_axi_awvalid} = 4'h0;
		{s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 4'h0;
		{nvm_byte_i, s_axi_wstrb, fw_op_i} = {8'h00, 4'hF, 6'h00};
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
		// Before loading, the reset byte of zero decodes as secure with
		// mass erase and factory access open, and no backdoor key.
		@(negedge clk_i) chk(status_o, 6'h2C);
		// Every byte value covers each field code in every combination.
		for (int i = 0; i < 256; i++) ld(i[7:0]);
		xfer(1'b1, FSOD_ADDR_PROTECT, 32'h0000_0005);
		chk(rsp, FSOD_RESP_OKAY);
		xfer(1'b0, FSOD_ADDR_PROTECT, 32'h0);
		chk(q, 32'h0000_0005);
		// Only the second byte lane may change under this strobe.
		s_axi_wstrb <= 4'h2;
		xfer(1'b1, FSOD_ADDR_PROTECT, 32'hFFFF_FFFF);
		chk(rsp, FSOD_RESP_OKAY);
		xfer(1'b0, FSOD_ADDR_PROTECT, 32'h0);
		chk(q, 32'h0000_FF05);
		s_axi_wstrb <= 4'hF;
		xfer(1'b0, FSOD_ADDR_CONTROL, 32'h0);
		chk(q, 32'h0000_0000);
		chk(rsp, FSOD_RESP_OKAY);
		op(6'h20, 1'b0);
		op(6'h21, 1'b1);
		op(6'h00, 1'b1);
		xfer(1'b0, FSOD_ADDR_SECBYTE, 32'h0);
		chk(q, 32'h0000_00FF);
		xfer(1'b0, FSOD_ADDR_STATUS, 32'h0);
		chk(q, {26'h0, dec(8'hFF)});
		xfer(1'b1, FSOD_ADDR_SECBYTE, 32'h0);
		chk(rsp, FSOD_RESP_SLVERR);
		xfer(1'b0, 32'h0000_0010, 32'h0);
		chk(rsp, FSOD_RESP_SLVERR);
		unl(8'hA0, 1'b1, 4'hB);
		unl(8'hA0, 1'b0, 4'h5);
		unl(8'h60, 1'b1, 4'h5);
		close_out;
	end
endmodule // fsod_top_tb
